/* common/slm_pkg.sv */
// Shared constants and types of the slow-mode loader.
// Assumes it is compiled before every file that names slm_pkg.
package slm_pkg;

  // ****************************************************************
  // Instruction word layout
  // ****************************************************************
  localparam int INSTR_W = 64;  // One external store word.
  localparam int OPCODE_W = 3;  // Opcode, bits 63 to 61.
  localparam int SRC_W = 18;  // Source word address, bits 60 to 43.
  localparam int COUNT_W = 8;  // Word count, bits 42 to 35.
  localparam int SEL_W = 5;  // Destination selector, bits 34 to 30.
  localparam int DST_W = 8;  // Destination start address, bits 29 to 22.
  localparam int SPARE_W = 22;  // Ignored, bits 21 to 0.

  // Decoded view of one fetched word, most significant field first.
  typedef struct packed {
    logic [OPCODE_W-1:0] opcode;
    logic [SRC_W-1:0] source_word_address;
    logic [COUNT_W-1:0] count;
    logic [SEL_W-1:0] sel;
    logic [DST_W-1:0] destination_start_address;
    logic [SPARE_W-1:0] spare;
  } slm_instr_s;

  // ****************************************************************
  // Opcodes and destination selectors
  // ****************************************************************
  localparam logic [OPCODE_W-1:0] OP_NOP = 3'h0;
  localparam logic [OPCODE_W-1:0] OP_RUN = 3'h1;
  localparam logic [OPCODE_W-1:0] OP_HALT = 3'h3;
  localparam logic [OPCODE_W-1:0] OP_BLOCK_COPY = 3'h5;
  localparam logic [SEL_W-1:0] SEL_ADDRESS = 5'h10;
  localparam logic [SEL_W-1:0] SEL_STREAM = 5'h08;
  localparam logic [SEL_W-1:0] SEL_FAST_PROG = 5'h04;
  localparam logic [SEL_W-1:0] SEL_POINTER = 5'h02;
  localparam logic [SEL_W-1:0] SEL_LOOP = 5'h01;

  // ****************************************************************
  // Internal memory shapes
  // ****************************************************************
  localparam int ADDRESS_W = 56;
  localparam int STREAM_W = 37;
  localparam int FAST_PROG_W = 54;
  localparam int POINTER_W = 8;
  localparam int LOOP_W = 32;
  localparam int SMALL_DEPTH = 32;
  localparam int SMALL_AW = 5;
  localparam int FAST_PROG_DEPTH = 256;
  localparam logic [SRC_W-1:0] RESET_PC = 18'h0_0000;

  // ****************************************************************
  // APB register map and status layout
  // ****************************************************************
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] REG_CONTROL = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] REG_PC = 8'h08;
  localparam int CTRL_RESUME_BIT = 0;
  localparam int STAT_SLOW_BIT = 0;
  localparam int STAT_FAST_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_COPY_BIT = 3;

  // Controller states.
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_DECODE,
    ST_COPY,
    ST_FAST,
    ST_HALT
  } slm_state_e;

endpackage

/* rtl/slm_loader.sv */
// Slow-mode loader: fetches external program words, copies data into
// the five internal memories, then hands over to fast mode.
// Assumes the external program store and the fast-mode unit run on
// sys_clk, so their signals need no synchroniser.
//
// What this block does
// - Start slow mode fetching at word zero.
// - Freeze held high throughout slow mode.
// - Every instruction is one 64-bit word.
// - Opcode 63:61, source address 60:43.
// - Word count from bits 42:35.
// - Selector 34:30, destination 29:22, rest ignored.
// - Opcode zero changes nothing.
// - Run enters fast mode at first pointer.
// - Halt stops all further execution.
// - Block copy moves count plus one words.
// - Source addresses count whole 64-bit words.
// - Each word fills one entry, truncated.
// - Writes start at destination, in order.
// - Selector 10000 targets address init memory.
// - Selector 01000 targets stream control memory.
// - Selector 00100 targets fast program store.
// - Selector 00010 targets pointer init memory.
// - Selector 00001 targets loop count memory.
// - Depth 32 each, fast store 256.
`timescale 1ns/100ps
`default_nettype none

module slm_loader #(
  parameter int FIRST_IP_INDEX = 1  // Pointer entry that starts fast mode.
) (
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slm_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External program store read channel.
  output logic store_rd,
  output logic [slm_pkg::SRC_W-1:0] store_addr,
  input wire logic [slm_pkg::INSTR_W-1:0] store_rdata,
  input wire logic store_rvalid,
  // Memory system under test.
  output logic freeze,
  // Fast-mode hand-over and memory read port.
  output logic fast_mode,
  output logic [slm_pkg::POINTER_W-1:0] first_instruction_pointer,
  input wire logic [slm_pkg::SEL_W-1:0] rd_sel,
  input wire logic [slm_pkg::DST_W-1:0] rd_addr,
  output logic [slm_pkg::INSTR_W-1:0] rd_data
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  slm_pkg::slm_state_e state;  // Controller state.
  slm_pkg::slm_instr_s instr;  // Word under decode.
  logic [slm_pkg::SRC_W-1:0] pc;  // Next instruction word address.
  logic [slm_pkg::SRC_W-1:0] src;  // Current copy source word.
  logic [slm_pkg::COUNT_W-1:0] remain;  // Words left after this one.
  logic [slm_pkg::DST_W-1:0] dst;  // Current copy destination entry.
  logic [slm_pkg::SEL_W-1:0] dst_sel;  // Latched one-hot selector.
  logic copy_we;  // One destination entry written this cycle.
  logic apb_access;  // Access phase waiting for its answer.
  logic apb_done;  // Edge at which the transfer completes.
  logic resume;  // Software asks to go back to slow mode.
  logic [31:0] next_prdata;  // Read value for the addressed register.
  logic next_pslverr;  // Address not in the map.

  // The five internal memories. No reset: contents are loaded by
  // software through block copies before fast mode reads them.
  // Leaving them without reset lets synthesis map them onto RAM
  // macros; the cost is that an entry read before any copy is
  // unknown, so a program must load whatever it later uses.
  logic [slm_pkg::ADDRESS_W-1:0] address_init_memory [slm_pkg::SMALL_DEPTH];
  logic [slm_pkg::STREAM_W-1:0] stream_ctrl_init_memory [slm_pkg::SMALL_DEPTH];
  logic [slm_pkg::FAST_PROG_W-1:0] fast_program_store
    [slm_pkg::FAST_PROG_DEPTH];
  logic [slm_pkg::POINTER_W-1:0] pointer_init_memory [slm_pkg::SMALL_DEPTH];
  logic [slm_pkg::LOOP_W-1:0] loop_count_init_memory [slm_pkg::SMALL_DEPTH];

  // ****************************************************************
  // APB handshake
  // ****************************************************************

  // An access is answered one cycle after penable rises; pready is a
  // flop so the answer never depends combinationally on the master.
  // The price is one fixed wait state on every transfer, which is
  // harmless here: software only polls status and pokes resume.
  assign apb_access = psel && penable && !pready;
  assign apb_done = psel && penable && pready;
  assign resume = apb_done && pwrite && (paddr == slm_pkg::REG_CONTROL)
    && pwdata[slm_pkg::CTRL_RESUME_BIT];

  // Read mux for the addressed register; unmapped reads return zero.
  // Misaligned offsets fall into the default arm and are refused
  // with pslverr, since every register is one whole aligned word.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      slm_pkg::REG_CONTROL: begin
        next_prdata = 32'h0000_0000;
      end
      slm_pkg::REG_STATUS: begin
        next_prdata[slm_pkg::STAT_SLOW_BIT] = freeze;
        next_prdata[slm_pkg::STAT_FAST_BIT] = fast_mode;
        next_prdata[slm_pkg::STAT_HALT_BIT] = (state == slm_pkg::ST_HALT);
        next_prdata[slm_pkg::STAT_COPY_BIT] = (state == slm_pkg::ST_COPY);
      end
      slm_pkg::REG_PC: begin
        next_prdata[slm_pkg::SRC_W-1:0] = pc;
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // Ready pulses for one cycle per transfer.
  // The !pready term in apb_access stops a second pulse while the
  // master still holds the completed access phase.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_access;
    end
  end

  // Read data and error are set with ready and held otherwise.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_access) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // Instruction sequencer
  // ****************************************************************

  // Fetch, decode and copy. The read request is a level: address and
  // request stand until store_rvalid acknowledges them with data.
  // The store may take any number of cycles; nothing here counts
  // them, so a slow store only stretches the slow-mode load time.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= slm_pkg::ST_FETCH;
      pc <= slm_pkg::RESET_PC;
      store_rd <= 1'b1;
      store_addr <= slm_pkg::RESET_PC;
      instr <= '0;
      src <= '0;
      remain <= '0;
      dst <= '0;
      dst_sel <= '0;
    end else begin
      unique case (state)
        slm_pkg::ST_FETCH: begin
          // Wait here, request held, until the store answers.
          if (store_rvalid) begin
            // The whole 64-bit word is one instruction.
            instr <= store_rdata;
            store_rd <= 1'b0;
            state <= slm_pkg::ST_DECODE;
          end
        end
        slm_pkg::ST_DECODE: begin
          // The request is low for this one cycle while the opcode and
          // selector are examined; a bad selector never opens a copy.
          if (instr.opcode == slm_pkg::OP_RUN) begin
            // Resume in slow mode at the word after the run.
            pc <= pc + 1'b1;
            state <= slm_pkg::ST_FAST;
          end else if (instr.opcode == slm_pkg::OP_HALT) begin
            state <= slm_pkg::ST_HALT;
          end else if (instr.opcode == slm_pkg::OP_BLOCK_COPY
                       && $onehot(instr.sel)) begin
            src <= instr.source_word_address;
            remain <= instr.count;
            dst_sel <= instr.sel;
            dst <= instr.destination_start_address;
            store_rd <= 1'b1;
            store_addr <= instr.source_word_address;
            state <= slm_pkg::ST_COPY;
          end else begin
            // No-op, undefined opcodes and bad selectors all land here.
            pc <= pc + 1'b1;
            store_rd <= 1'b1;
            store_addr <= pc + 1'b1;
            state <= slm_pkg::ST_FETCH;
          end
        end
        slm_pkg::ST_COPY: begin
          // Each answered word is written below through copy_we; here
          // source, destination and remaining count step to the next.
          if (store_rvalid) begin
            if (remain == '0) begin
              // Last of count plus one words; request stays up.
              pc <= pc + 1'b1;
              store_addr <= pc + 1'b1;
              state <= slm_pkg::ST_FETCH;
            end else begin
              remain <= remain - 1'b1;
              src <= src + 1'b1;
              store_addr <= src + 1'b1;
              dst <= dst + 1'b1;
            end
          end
        end
        slm_pkg::ST_FAST: begin
          // The fast-mode units own the machine until software resumes;
          // the request stays low, so the store sees no traffic meanwhile.
          if (resume) begin
            store_rd <= 1'b1;
            store_addr <= pc;
            state <= slm_pkg::ST_FETCH;
          end
        end
        slm_pkg::ST_HALT: begin
          // Only reset leaves this state.
          state <= slm_pkg::ST_HALT;
        end
      endcase
    end
  end

  // ****************************************************************
  // Mode outputs
  // ****************************************************************

  // Freeze follows slow mode; fast mode owns the line while it runs,
  // which is outside this block, so here it is simply released.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      freeze <= 1'b1;
      fast_mode <= 1'b0;
    end else if (state == slm_pkg::ST_DECODE
                 && instr.opcode == slm_pkg::OP_RUN) begin
      freeze <= 1'b0;
      fast_mode <= 1'b1;
    end else if (state == slm_pkg::ST_FAST && resume) begin
      freeze <= 1'b1;
      fast_mode <= 1'b0;
    end
  end

  // The starting pointer is sampled when run decodes, so later copies
  // cannot move it under a fast-mode program already running.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      first_instruction_pointer <= '0;
    end else if (state == slm_pkg::ST_DECODE
                 && instr.opcode == slm_pkg::OP_RUN) begin
      first_instruction_pointer <=
        pointer_init_memory[FIRST_IP_INDEX[slm_pkg::SMALL_AW-1:0]];
    end
  end

  // ****************************************************************
  // Internal memories
  // ****************************************************************

  // A word is written on every edge at which the store answers a copy.
  assign copy_we = (state == slm_pkg::ST_COPY) && store_rvalid;

  // One entry per moved word, low bits only. Destinations in the
  // 32-deep memories wrap on the low five address bits.
  // Wrapping is cheaper than refusing an out-of-range start, and a
  // copy that runs past the end simply continues from entry zero.
  always_ff @(posedge sys_clk) begin
    if (copy_we) begin
      unique case (dst_sel)
        slm_pkg::SEL_ADDRESS: begin
          address_init_memory[dst[slm_pkg::SMALL_AW-1:0]] <=
            store_rdata[slm_pkg::ADDRESS_W-1:0];
        end
        slm_pkg::SEL_STREAM: begin
          stream_ctrl_init_memory[dst[slm_pkg::SMALL_AW-1:0]] <=
            store_rdata[slm_pkg::STREAM_W-1:0];
        end
        slm_pkg::SEL_FAST_PROG: begin
          fast_program_store[dst] <=
            store_rdata[slm_pkg::FAST_PROG_W-1:0];
        end
        slm_pkg::SEL_POINTER: begin
          pointer_init_memory[dst[slm_pkg::SMALL_AW-1:0]] <=
            store_rdata[slm_pkg::POINTER_W-1:0];
        end
        slm_pkg::SEL_LOOP: begin
          loop_count_init_memory[dst[slm_pkg::SMALL_AW-1:0]] <=
            store_rdata[slm_pkg::LOOP_W-1:0];
        end
        default: begin
          // Not reachable: decode admits one-hot selectors only.
        end
      endcase
    end
  end

  // Registered read port for the fast-mode units, zero-extended.
  // The read is registered so fast-mode timing sees one fixed cycle
  // of latency whichever memory is selected.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      unique case (rd_sel)
        slm_pkg::SEL_ADDRESS: begin
          rd_data <= 64'(address_init_memory[rd_addr[slm_pkg::SMALL_AW-1:0]]);
        end
        slm_pkg::SEL_STREAM: begin
          rd_data <=
            64'(stream_ctrl_init_memory[rd_addr[slm_pkg::SMALL_AW-1:0]]);
        end
        slm_pkg::SEL_FAST_PROG: begin
          rd_data <= 64'(fast_program_store[rd_addr]);
        end
        slm_pkg::SEL_POINTER: begin
          rd_data <= 64'(pointer_init_memory[rd_addr[slm_pkg::SMALL_AW-1:0]]);
        end
        slm_pkg::SEL_LOOP: begin
          rd_data <=
            64'(loop_count_init_memory[rd_addr[slm_pkg::SMALL_AW-1:0]]);
        end
        default: begin
          // A selector that is not one-hot reads zero.
          rd_data <= '0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* test/slm_store_model.sv */
// External program store model for the slow-mode loader.
// Assumes the loader's read channel runs on sys_clk; the bench fills mem.
`timescale 1ns/100ps
`default_nettype none
module slm_store_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic store_rd,
  input wire logic [slm_pkg::SRC_W-1:0] store_addr,
  input wire logic [3:0] lat,
  output logic [slm_pkg::INSTR_W-1:0] store_rdata,
  output logic store_rvalid
);
  // ****************************************************************
  // Storage and answer timing
  // ****************************************************************
  logic [63:0] mem [0:127];  // One 64-bit word per address.
  logic [3:0] wait_cnt;  // Cycles the open request has waited.
  // A zero latency answers at once, so a copy runs a word per cycle.
  assign store_rvalid = store_rd && (wait_cnt >= lat);
  // Outside a valid beat the data is inverted, so stale data never passes.
  assign store_rdata = store_rvalid ? mem[store_addr[6:0]]
                                    : ~mem[store_addr[6:0]];
  // Count waiting cycles; restart when the request is taken or dropped.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 4'h0;
    end else if (!store_rd || store_rvalid) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* test/slm_loader_checker.sv */
// Concurrent checks on the ports of the slow-mode loader.
// Assumes one clock domain, sys_clk, with nrst as its reset.
`timescale 1ns/100ps
`default_nettype none
module slm_loader_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slm_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic store_rd,
  input wire logic [slm_pkg::SRC_W-1:0] store_addr,
  input wire logic [slm_pkg::INSTR_W-1:0] store_rdata,
  input wire logic store_rvalid,
  input wire logic freeze,
  input wire logic fast_mode,
  input wire logic [slm_pkg::POINTER_W-1:0] first_instruction_pointer,
  input wire logic [slm_pkg::SEL_W-1:0] rd_sel,
  input wire logic [slm_pkg::DST_W-1:0] rd_addr,
  input wire logic [slm_pkg::INSTR_W-1:0] rd_data
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_freeze_slow:
  assert property (!fast_mode |-> freeze) else $error("freeze dropped");
  chk_reset_start:
  assert property (!$past(nrst) |-> store_rd && store_addr == 18'h0_0000)
    else $error("first fetch not at word zero");
  chk_req_hold:
  assert property (store_rd && !store_rvalid |=>
    store_rd && $stable(store_addr))
    else $error("store request moved before answer");
  chk_run_entry:
  assert property ($rose(fast_mode) |-> !freeze && !$past(store_rd))
    else $error("fast mode entered outside decode");
  chk_fast_quiet:
  assert property (fast_mode |-> !store_rd) else $error("fetch in fast mode");
  chk_apb_wait:
  assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  chk_apb_setup:
  assert property (psel && !penable |=> !pready) else $error("early ready");
  chk_apb_single:
  assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  chk_apb_unmapped:
  assert property (pready && paddr > 8'h08 |-> pslverr)
    else $error("unmapped access not refused");
  // Main scenarios reached.
  cover property ($rose(fast_mode));
  cover property ($fell(fast_mode));
  cover property (pready && pslverr);
  cover property (store_rvalid && store_rd ##1 store_rvalid && store_rd);
endmodule
bind slm_loader slm_loader_checker u_slm_loader_checker (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .store_rd(store_rd),
  .store_addr(store_addr), .store_rdata(store_rdata),
  .store_rvalid(store_rvalid), .freeze(freeze), .fast_mode(fast_mode),
  .first_instruction_pointer(first_instruction_pointer),
  .rd_sel(rd_sel), .rd_addr(rd_addr), .rd_data(rd_data));
`default_nettype wire

/* test/test_slm_loader.sv */
// Self-checking bench: loads all five memories, runs, resumes, halts.
// Assumes slm_pkg, the store model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_slm_loader;
  localparam int FIP = 1;  // Pointer entry that starts fast mode.
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, re;
  logic store_rd, store_rvalid, freeze, fast_mode;
  logic [7:0] paddr, rd_addr, first_instruction_pointer;
  logic [31:0] pwdata, prdata, rq;
  logic [17:0] store_addr;
  logic [63:0] store_rdata, rd_data;
  logic [4:0] rd_sel;
  logic [3:0] lat;
  int n_errors, checked, k;
  logic [4:0] t_sel [5];  // Copy table: selector, width, count, start.
  int t_w [5];
  int t_cnt [5];
  logic [7:0] t_dst [5];

  slm_loader #(.FIRST_IP_INDEX(FIP)) u_slm_loader (.sys_clk(sys_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .store_rd(store_rd), .store_addr(store_addr),
    .store_rdata(store_rdata), .store_rvalid(store_rvalid),
    .freeze(freeze), .fast_mode(fast_mode),
    .first_instruction_pointer(first_instruction_pointer),
    .rd_sel(rd_sel), .rd_addr(rd_addr), .rd_data(rd_data));
  slm_store_model u_slm_store_model (.sys_clk(sys_clk), .nrst(nrst),
    .store_rd(store_rd), .store_addr(store_addr), .lat(lat),
    .store_rdata(store_rdata), .store_rvalid(store_rvalid));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [63:0] mk(logic [2:0] op, logic [17:0] src,
      logic [7:0] cnt, logic [4:0] sel, logic [7:0] dst);
    return {op, src, cnt, sel, dst, 22'h2a_aaaa};  // Alternate spare bits set.
  endfunction
  function automatic logic [63:0] dat(int a);
    return {16'hc3a5, 8'(a), 8'h5a, 16'h96e1, 8'h3c, 8'(a)};
  endfunction
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No count of its own: a slave that never answers meets the watchdog.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [4:0] s, input logic [7:0] a, input logic [63:0] e);
    @(posedge sys_clk);
    rd_sel <= s;
    rd_addr <= a;
    @(posedge sys_clk);
    #1 check(rd_data, e);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    #1 check({store_addr, store_rd, freeze, fast_mode}, 64'h6);
    @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  // Wait for the hand-over, then read back every copied entry.
  task t_load;
    for (k = 0; k < 3000 && fast_mode !== 1'b1; k++) @(posedge sys_clk);
    #1 check({freeze, first_instruction_pointer}, 64'h58);
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j <= t_cnt[i]; j++) begin
        rd_chk(t_sel[i], t_dst[i] + 8'(j), dat(64 + 8 * i + j) &
          ((64'h1 << t_w[i]) - 64'h1));
      end
    end
  endtask
  task t_regs;
    apb(1'b0, slm_pkg::REG_STATUS, '0);
    check(rq, 64'h2);
    apb(1'b0, slm_pkg::REG_PC, '0);
    check(rq, 64'ha);
    apb(1'b0, 8'h0c, '0);
    check({re, rq}, 64'h1_0000_0000);
  endtask
  // Resume slow fetch with a slow store; the next word halts the loader.
  task t_halt;
    @(posedge sys_clk);
    lat <= 4'h3;
    apb(1'b1, slm_pkg::REG_CONTROL, 32'h0000_0001);
    for (k = 0; k < 30 && rq !== 32'h0000_0005; k++) begin
      apb(1'b0, slm_pkg::REG_STATUS, '0);
    end
    check(rq, 64'h5);
    repeat (10) @(posedge sys_clk);
    #1 check({store_rd, freeze, fast_mode}, 64'h2);
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    conclude;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rd_sel, rd_addr} = '0;
    {nrst, lat, n_errors, checked} = '0;
    t_sel = '{slm_pkg::SEL_ADDRESS, slm_pkg::SEL_STREAM,
      slm_pkg::SEL_FAST_PROG, slm_pkg::SEL_POINTER, slm_pkg::SEL_LOOP};
    t_w = '{slm_pkg::ADDRESS_W, slm_pkg::STREAM_W, slm_pkg::FAST_PROG_W,
      slm_pkg::POINTER_W, slm_pkg::LOOP_W};
    t_cnt = '{2, 1, 1, 0, 3};
    t_dst = '{8'h1d, 8'h00, 8'hfe, 8'(FIP), 8'h04};
    for (k = 0; k < 128; k++) u_slm_store_model.mem[k] = dat(k);
    u_slm_store_model.mem[0] = mk(slm_pkg::OP_NOP, '1, '1, '1, '1);
    for (k = 0; k < 5; k++) begin
      u_slm_store_model.mem[k + 1] = mk(slm_pkg::OP_BLOCK_COPY,
        18'(64 + 8 * k), 8'(t_cnt[k]), t_sel[k], t_dst[k]);
    end
    u_slm_store_model.mem[6] = mk(slm_pkg::OP_BLOCK_COPY, 18'h0_0070,
      8'h00, 5'h03, 8'(FIP));
    u_slm_store_model.mem[7] = mk(3'h7, 18'h0_0070, 8'h00,
      slm_pkg::SEL_LOOP, 8'h04);
    u_slm_store_model.mem[8] = mk(3'h2, '0, '0, '0, '0);
    u_slm_store_model.mem[9] = mk(slm_pkg::OP_RUN, '0, '0, '0, '0);
    u_slm_store_model.mem[10] = mk(slm_pkg::OP_HALT, '0, '0, '0, '0);
    repeat (16) @(posedge sys_clk);
    t_reset;
    t_load;
    t_regs;
    t_halt;
    conclude;
  end
endmodule
`default_nettype wire
